// File: src/uafc_pkg.sv
package uafc_pkg;
  // Register offsets on the host register port
  localparam logic [4:0] OFS_RECV_HOLD = 5'h00;
  localparam logic [4:0] OFS_TOP_MASK = 5'h01;
  localparam logic [4:0] OFS_TOP_STAT = 5'h02;
  localparam logic [4:0] OFS_LINE_MASK = 5'h03;
  localparam logic [4:0] OFS_LINE_COND = 5'h04;
  localparam logic [4:0] OFS_SPC_MASK = 5'h05;
  localparam logic [4:0] OFS_SPC_IRQ = 5'h06;
  localparam logic [4:0] OFS_MISC_MASK = 5'h07;
  localparam logic [4:0] OFS_MISC_IRQ = 5'h08;
  localparam logic [4:0] OFS_PRIMARY = 5'h09;
  localparam logic [4:0] OFS_HS_CFG = 5'h0A;
  localparam logic [4:0] OFS_HS_THR = 5'h0B;
  localparam logic [4:0] OFS_TRIG = 5'h0C;
  localparam logic [4:0] OFS_RES1 = 5'h0D;
  localparam logic [4:0] OFS_RES2 = 5'h0E;
  localparam logic [4:0] OFS_PAU1 = 5'h0F;
  localparam logic [4:0] OFS_PAU2 = 5'h10;
  localparam logic [4:0] OFS_REVISION = 5'h11;
  // Field positions
  localparam int CTL_TX_DIS = 1;
  localparam int CTL_FSLEEP = 5;
  localparam int CTL_ASLEEP = 6;
  localparam int CTL_IRQ_SEL = 7;
  localparam int HCF_TX_LSB = 4;
  localparam int HCF_RX_LSB = 6;
  localparam int THR_HALT_LSB = 0;
  localparam int THR_RES_LSB = 4;
  localparam int TRG_TX_LSB = 0;
  localparam int TRG_RX_LSB = 4;
  localparam int LEVEL_SHIFT = 3;
  localparam int IRQ_LINE = 0;
  localparam int IRQ_SPC = 1;
  localparam int IRQ_MISC = 2;
  localparam int IRQ_RXTRG = 3;
  localparam int IRQ_TXTRG = 4;
  localparam int IRQ_TXEMP = 5;
  localparam int IRQ_RXEMP = 6;
  localparam int IRQ_CTS = 7;
  localparam int SPC_RESUME = 0;
  localparam int SPC_PAUSE = 1;
  localparam int LINE_OVR = 1;
  localparam int LINE_CTS = 7;
  localparam int MISC_CLK_RDY = 5;
  // Reset values and encodings
  localparam logic [7:0] TOP_STAT_RST = 8'h60;
  localparam logic [1:0] FC_OFF = 2'h0;
  localparam logic [1:0] FC_SINGLE = 2'h1;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYC = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_TIME_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CHARS = 65536;
  localparam int HOLD_TICKS = 2;
  // Host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } uafc_reg_req_s;
  // Flow-control state of the receive side
  typedef enum {UAFC_OPEN, UAFC_SEND_PAUSE, UAFC_HELD, UAFC_SEND_RESUME}
    uafc_flow_e;
endpackage

// File: src/uafc_tick_cnt.sv
`timescale 1ns/1ps
// Counts enable ticks up to a limit and then holds done high
module uafc_tick_cnt #(
  parameter int W = 17,
  parameter int LIMIT = 65536
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic tick,
  // Status
  output logic done
);
  logic [W-1:0] cnt_q;

  // Clear wins over a tick so a restart is never one count short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (clr) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (tick && !done) begin
      if (cnt_q == W'(LIMIT - 1)) begin
        done <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// File: src/uafc_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer; head feeds the output, spare absorbs a stall
module uafc_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic spare_v;
  logic [W-1:0] spare_q;
  logic push;
  logic pop;

  // Ready comes from a flop, so the source never sees a loop
  assign in_ready = !spare_v;
  assign push = in_valid && !spare_v;
  assign pop = out_valid && out_ready;

  // Head and spare move together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_v <= 1'b0;
      spare_q <= '0;
    end else if (pop) begin
      if (spare_v) begin
        out_data <= spare_q;
        spare_v <= 1'b0;
      end else if (push) begin
        out_data <= in_data;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else begin
        spare_q <= in_data;
        spare_v <= 1'b1;
      end
    end
  end
endmodule

// File: src/uafc_core.sv
`timescale 1ns/1ps
// Behaviour
// - Single or paired 8-bit pause/resume characters
// - Config bits 7:4 set flow control modes
// - Received pause/resume sets special-character interrupt
// - Received pause stops transmit, resume restarts
// - Matched pause/resume characters never reach FIFO
// - Send pause when receive level reaches halt
// - Send resume when level falls to resume
// - First character goes before second character
// - Trigger bits set at or above level
// - Forced sleep stops UART clocks, registers live
// - Autosleep after idle characters, wake on activity
// - Clock-ready flag after wake, not external clock
// - Reset clears every setting; host must reprogram
// - Interrupt pin low until initialization completes
// - After init, pin active only for enabled pending interrupts
// - Top status summarises three low-level registers
// - Top status, special, misc clear on read
// - Line bits clear only when condition goes
// - Read at 0x00 pops oldest received character
// - Halt threshold from low four threshold bits, in steps of eight
module uafc_core #(
  parameter int DEPTH = 128,
  parameter int IDLE_LIMIT = uafc_pkg::IDLE_CHARS,
  parameter logic [7:0] REV_ID = 8'hA5
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Host register port
  input wire uafc_pkg::uafc_reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Words from the receiver and character-rate tick
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic CHAR_TICK,
  // Transmit FIFO head
  input wire logic TXQ_VALID,
  input wire logic [7:0] TXQ_DATA,
  input wire logic [7:0] TXQ_LEVEL,
  output logic TXQ_TAKE,
  // Transmitter
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Pins and clock source
  input wire logic RX_PIN,
  input wire logic CTS_N,
  input wire logic [3:0] GPIO_IN,
  input wire logic EXT_CLK,
  // Status
  output logic IRQ_N,
  output logic UART_CLK_EN
);
  import uafc_pkg::*;

  localparam int LW = $clog2(DEPTH) + 1;

  // Host-visible registers
  logic [7:0] primary_control_reg_q, handshake_config_reg_q;
  logic [7:0] handshake_threshold_reg_q, queue_trigger_levels_q;
  logic [7:0] resume_char_first_q, resume_char_second_q;
  logic [7:0] pause_char_first_q, pause_char_second_q;
  logic [7:0] top_irq_mask_q, line_condition_mask_q;
  logic [7:0] special_char_mask_q, misc_status_mask_q;
  logic [7:0] top_irq_status_q, special_char_irq_q, misc_status_irq_q;
  logic [7:0] line_condition_reg_q;
  // Receive FIFO storage and pointers
  logic [7:0] rx_mem_q [DEPTH];
  logic [LW-2:0] rx_wp_q, rx_rp_q;
  logic [LW-1:0] rx_lvl_q;
  // Pending first half of a paired character
  logic hold_v_q;
  logic [7:0] hold_q;
  logic [1:0] hold_age_q;
  // Flow and sleep state
  uafc_flow_e flow_q;
  logic second_q, tx_halt_q, auto_sleep_q, sleep_q;
  logic take_q, rdy_q, cts_q, rxp_q;
  logic [3:0] gpio_q;
  // Combinational helpers
  logic rd_stb, wr_stb, pop, rx_full, rx_push, ovf;
  logic [7:0] push_data, spc_ev, flow_char, tx_word, pin_irq;
  logic tx_fc, tx_dual, rx_fc, rx_dual, flow_push, take_now;
  logic buf_ready, sleep, activity, idle_clr, idle_done;
  logic init_done, settle_done, match_p, match_r;
  logic [LW-1:0] halt_lvl, res_lvl, rtrg_lvl, ttrg_lvl;

  assign rd_stb = REG_REQ.rd;
  assign wr_stb = REG_REQ.wr;
  assign pop = rd_stb && (REG_REQ.addr == OFS_RECV_HOLD) && (rx_lvl_q != 0);
  assign rx_full = (rx_lvl_q == LW'(DEPTH));
  assign tx_fc = handshake_config_reg_q[HCF_TX_LSB+:2] != FC_OFF;
  assign tx_dual = tx_fc && handshake_config_reg_q[HCF_TX_LSB+:2] != FC_SINGLE;
  assign rx_fc = handshake_config_reg_q[HCF_RX_LSB+:2] != FC_OFF;
  assign rx_dual = rx_fc && handshake_config_reg_q[HCF_RX_LSB+:2] != FC_SINGLE;
  assign halt_lvl = LW'(handshake_threshold_reg_q[THR_HALT_LSB+:4]) << LEVEL_SHIFT;
  assign res_lvl = LW'(handshake_threshold_reg_q[THR_RES_LSB+:4]) << LEVEL_SHIFT;
  assign rtrg_lvl = LW'(queue_trigger_levels_q[TRG_RX_LSB+:4]) << LEVEL_SHIFT;
  assign ttrg_lvl = LW'(queue_trigger_levels_q[TRG_TX_LSB+:4]) << LEVEL_SHIFT;

  // forced or automatic sleep gates all UART clocking
  assign sleep = primary_control_reg_q[CTL_FSLEEP] || auto_sleep_q;

  // compare received words with the pause and resume codes
  always_comb begin
    match_p = 1'b0;
    match_r = 1'b0;
    rx_push = 1'b0;
    push_data = RX_DATA;
    spc_ev = 8'h00;
    if (RX_VALID && !sleep) begin
      if (!tx_fc) begin
        rx_push = 1'b1;
      end else if (!tx_dual) begin
        match_p = RX_DATA == pause_char_first_q;
        match_r = RX_DATA == resume_char_first_q;
        rx_push = !match_p && !match_r;
      end else if (hold_v_q) begin
        // paired characters match only as a whole
        match_p = hold_q == pause_char_first_q && RX_DATA == pause_char_second_q;
        match_r = hold_q == resume_char_first_q && RX_DATA == resume_char_second_q;
        rx_push = !match_p && !match_r;
        push_data = hold_q;
      end
    end else if (hold_v_q && hold_age_q == 2'(HOLD_TICKS)) begin
      // A lone first half is released once the line goes quiet
      rx_push = 1'b1;
      push_data = hold_q;
    end
    spc_ev[SPC_PAUSE] = match_p;
    spc_ev[SPC_RESUME] = match_r;
  end
  assign ovf = rx_push && rx_full && !pop;

  // Paired mode keeps a candidate first half back from the FIFO
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hold_v_q <= 1'b0;
      hold_q <= 8'h00;
      hold_age_q <= 2'h0;
    end else if (RX_VALID && !sleep && tx_dual) begin
      // a matched pair leaves nothing behind
      hold_v_q <= !(match_p || match_r);
      hold_q <= RX_DATA;
      hold_age_q <= 2'h0;
    end else if (rx_push || !tx_dual) begin
      hold_v_q <= 1'b0;
    end else if (hold_v_q && CHAR_TICK) begin
      hold_age_q <= hold_age_q + 2'h1;
    end
  end

  // Receive FIFO; a push and a pop in one cycle both count
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_lvl_q <= '0;
    end else begin
      if (rx_push && (!rx_full || pop)) begin
        rx_mem_q[rx_wp_q] <= push_data;
        rx_wp_q <= (rx_wp_q == (LW-1)'(DEPTH - 1)) ? '0 : rx_wp_q + 1'b1;
      end
      // holding read removes the oldest word
      if (pop) begin
        rx_rp_q <= (rx_rp_q == (LW-1)'(DEPTH - 1)) ? '0 : rx_rp_q + 1'b1;
      end
      rx_lvl_q <= rx_lvl_q + LW'(rx_push && (!rx_full || pop)) - LW'(pop);
    end
  end

  // remote pause stops the queue, resume restarts it
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_halt_q <= 1'b0;
    end else if (!tx_fc || match_r) begin
      tx_halt_q <= 1'b0;
    end else if (match_p) begin
      tx_halt_q <= 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flow_q <= UAFC_OPEN;
      second_q <= 1'b0;
    end else begin
      case (flow_q)
        UAFC_OPEN: begin
          if (rx_fc && rx_lvl_q >= halt_lvl) begin
            flow_q <= UAFC_SEND_PAUSE;
          end
        end
        UAFC_HELD: begin
          // resume once reads reach the resume level
          if (!rx_fc) begin
            flow_q <= UAFC_OPEN;
          end else if (rx_lvl_q <= res_lvl) begin
            flow_q <= UAFC_SEND_RESUME;
          end
        end
        UAFC_SEND_PAUSE, UAFC_SEND_RESUME: begin
          // first character, then the second one
          if (flow_push) begin
            if (rx_dual && !second_q) begin
              second_q <= 1'b1;
            end else begin
              second_q <= 1'b0;
              flow_q <= (flow_q == UAFC_SEND_PAUSE) ? UAFC_HELD : UAFC_OPEN;
            end
          end
        end
        default: flow_q <= UAFC_OPEN;
      endcase
    end
  end

  // flow characters enter the line buffer ahead of queue words
  assign flow_char = (flow_q == UAFC_SEND_PAUSE) ?
    (second_q ? pause_char_second_q : pause_char_first_q) :
    (second_q ? resume_char_second_q : resume_char_first_q);
  assign flow_push = buf_ready && !sleep &&
    (flow_q == UAFC_SEND_PAUSE || flow_q == UAFC_SEND_RESUME);
  // Takes are at least two cycles apart so the queue can advance
  assign take_now = buf_ready && !sleep && !flow_push && !take_q &&
    TXQ_VALID && !tx_halt_q && !primary_control_reg_q[CTL_TX_DIS];
  assign tx_word = flow_push ? flow_char : TXQ_DATA;

  // Take strobe back to the transmit FIFO
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      take_q <= 1'b0;
    end else begin
      take_q <= take_now;
    end
  end
  assign TXQ_TAKE = take_q;

  // Line buffer so a transmitter stall loses no word
  uafc_buf2 #(.W(8)) u_txbuf (
    .clk(MCLK),
    .rst(RST),
    .in_valid(flow_push || take_now),
    .in_ready(buf_ready),
    .in_data(tx_word),
    .out_valid(TX_VALID),
    .out_ready(TX_READY && !sleep),
    .out_data(TX_DATA)
  );

  // Pin history for activity and CTS edges
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cts_q <= 1'b1;
      rxp_q <= 1'b1;
      gpio_q <= 4'h0;
      sleep_q <= 1'b0;
    end else begin
      cts_q <= CTS_N;
      rxp_q <= RX_PIN;
      gpio_q <= GPIO_IN;
      sleep_q <= sleep;
    end
  end
  assign activity = (cts_q != CTS_N) || (rxp_q != RX_PIN) ||
    (gpio_q != GPIO_IN);

  // idle character count, restarted by anything going on
  assign idle_clr = activity || !primary_control_reg_q[CTL_ASLEEP] ||
    rx_lvl_q != 0 || TXQ_LEVEL != 8'h00 || (|pin_irq);
  uafc_tick_cnt #(.W($clog2(IDLE_LIMIT) + 1), .LIMIT(IDLE_LIMIT)) u_idle (
    .clk(MCLK),
    .rst(RST),
    .clr(idle_clr),
    .tick(CHAR_TICK),
    .done(idle_done)
  );
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      auto_sleep_q <= 1'b0;
    end else if (activity || !primary_control_reg_q[CTL_ASLEEP]) begin
      auto_sleep_q <= 1'b0;
    end else if (idle_done) begin
      auto_sleep_q <= 1'b1;
    end
  end

  // settle time runs from each wake
  uafc_tick_cnt #(.W(16), .LIMIT(SETTLE_CYC)) u_settle (
    .clk(MCLK),
    .rst(RST),
    .clr(sleep),
    .tick(1'b1),
    .done(settle_done)
  );
  uafc_tick_cnt #(.W(16), .LIMIT(INIT_CYC)) u_init (
    .clk(MCLK),
    .rst(RST),
    .clr(1'b0),
    .tick(1'b1),
    .done(init_done)
  );
  // Clocks on only while awake; registers stay live regardless
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      UART_CLK_EN <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      UART_CLK_EN <= init_done && !sleep;
      rdy_q <= settle_done;
    end
  end

  // status registers clear on read; a new event still wins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      special_char_irq_q <= 8'h00;
      misc_status_irq_q <= 8'h00;
    end else begin
      special_char_irq_q <= ((rd_stb && REG_REQ.addr == OFS_SPC_IRQ) ?
        8'h00 : special_char_irq_q) | spc_ev;
      misc_status_irq_q <= (rd_stb && REG_REQ.addr == OFS_MISC_IRQ) ?
        8'h00 : misc_status_irq_q;
      // external clock gives no readiness indication
      if (settle_done && !rdy_q && !EXT_CLK) begin
        misc_status_irq_q[MISC_CLK_RDY] <= 1'b1;
      end
    end
  end

  // line bits follow their cause, reads do not touch them
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      line_condition_reg_q <= 8'h00;
    end else begin
      line_condition_reg_q[LINE_CTS] <= CTS_N;
      if (ovf) begin
        line_condition_reg_q[LINE_OVR] <= 1'b1;
      end else if (!rx_full) begin
        line_condition_reg_q[LINE_OVR] <= 1'b0;
      end
    end
  end

  // top-level bits, three of them summarising detail registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      top_irq_status_q <= TOP_STAT_RST;
    end else begin
      // read with any bit set clears all bits
      top_irq_status_q <= ((rd_stb && REG_REQ.addr == OFS_TOP_STAT &&
        top_irq_status_q != 8'h00) ? 8'h00 : top_irq_status_q) | {
        cts_q != CTS_N,
        rx_lvl_q == 0,
        TXQ_LEVEL == 8'h00,
        // trigger bits at or above their level
        LW'(TXQ_LEVEL) >= ttrg_lvl && ttrg_lvl != 0,
        rx_lvl_q >= rtrg_lvl && rtrg_lvl != 0,
        |(misc_status_irq_q & misc_status_mask_q),
        |((special_char_irq_q | spc_ev) & special_char_mask_q),
        |(line_condition_reg_q & line_condition_mask_q)};
    end
  end

  // pin reflects enabled pending bits only
  assign pin_irq = top_irq_status_q & top_irq_mask_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      IRQ_N <= 1'b0;
    end else if (!init_done) begin
      IRQ_N <= 1'b0;
    end else if (primary_control_reg_q[CTL_IRQ_SEL]) begin
      IRQ_N <= ~(|pin_irq);
    end else begin
      // released high once ready for programming
      IRQ_N <= 1'b1;
    end
  end

  // every setting returns to its reset value
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      primary_control_reg_q <= 8'h00;
      handshake_config_reg_q <= 8'h00;
      handshake_threshold_reg_q <= 8'h00;
      queue_trigger_levels_q <= 8'h00;
      resume_char_first_q <= 8'h00;
      resume_char_second_q <= 8'h00;
      pause_char_first_q <= 8'h00;
      pause_char_second_q <= 8'h00;
      top_irq_mask_q <= 8'h00;
      line_condition_mask_q <= 8'h00;
      special_char_mask_q <= 8'h00;
      misc_status_mask_q <= 8'h00;
    end else if (wr_stb) begin
      case (REG_REQ.addr)
        OFS_PRIMARY: primary_control_reg_q <= REG_REQ.wdata;
        OFS_HS_CFG: handshake_config_reg_q <= REG_REQ.wdata;
        OFS_HS_THR: handshake_threshold_reg_q <= REG_REQ.wdata;
        OFS_TRIG: queue_trigger_levels_q <= REG_REQ.wdata;
        OFS_RES1: resume_char_first_q <= REG_REQ.wdata;
        OFS_RES2: resume_char_second_q <= REG_REQ.wdata;
        OFS_PAU1: pause_char_first_q <= REG_REQ.wdata;
        OFS_PAU2: pause_char_second_q <= REG_REQ.wdata;
        OFS_TOP_MASK: top_irq_mask_q <= REG_REQ.wdata;
        OFS_LINE_MASK: line_condition_mask_q <= REG_REQ.wdata;
        OFS_SPC_MASK: special_char_mask_q <= REG_REQ.wdata;
        OFS_MISC_MASK: misc_status_mask_q <= REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= rd_stb;
      if (rd_stb) begin
        case (REG_REQ.addr)
          OFS_RECV_HOLD: REG_RDATA <= (rx_lvl_q != 0) ? rx_mem_q[rx_rp_q] : 8'h00;
          OFS_TOP_MASK: REG_RDATA <= top_irq_mask_q;
          OFS_TOP_STAT: REG_RDATA <= top_irq_status_q;
          OFS_LINE_MASK: REG_RDATA <= line_condition_mask_q;
          OFS_LINE_COND: REG_RDATA <= line_condition_reg_q;
          OFS_SPC_MASK: REG_RDATA <= special_char_mask_q;
          OFS_SPC_IRQ: REG_RDATA <= special_char_irq_q;
          OFS_MISC_MASK: REG_RDATA <= misc_status_mask_q;
          OFS_MISC_IRQ: REG_RDATA <= misc_status_irq_q;
          OFS_PRIMARY: REG_RDATA <= primary_control_reg_q;
          OFS_HS_CFG: REG_RDATA <= handshake_config_reg_q;
          OFS_HS_THR: REG_RDATA <= handshake_threshold_reg_q;
          OFS_TRIG: REG_RDATA <= queue_trigger_levels_q;
          OFS_RES1: REG_RDATA <= resume_char_first_q;
          OFS_RES2: REG_RDATA <= resume_char_second_q;
          OFS_PAU1: REG_RDATA <= pause_char_first_q;
          OFS_PAU2: REG_RDATA <= pause_char_second_q;
          // Revision value is arbitrary
          OFS_REVISION: REG_RDATA <= REV_ID;
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule

// File: verification/uafc_core_sva.sv
`timescale 1ns/1ps
// Port-level checks on the control core
module uafc_core_sva (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire uafc_pkg::uafc_reg_req_s REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Transmit path
  input wire logic TXQ_VALID,
  input wire logic TXQ_TAKE,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Status
  input wire logic IRQ_N,
  input wire logic UART_CLK_EN
);
  import uafc_pkg::*;
  // Cycles since reset, saturating so it never wraps
  logic [7:0] age_q;
  // Shadow of the interrupt-select bit
  logic sel_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) age_q <= 8'h00;
    else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
  end
  // Follows host writes to the primary control register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) sel_q <= 1'b0;
    else if (REG_REQ.wr && REG_REQ.addr == OFS_PRIMARY)
      sel_q <= REG_REQ.wdata[CTL_IRQ_SEL];
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_rd_ans; REG_REQ.rd |=> REG_RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_unmap;
    REG_REQ.rd && REG_REQ.addr > OFS_REVISION |=> REG_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // Slack of three cycles keeps the check clear of the release edge
  property p_init; age_q < 8'h62 |-> !IRQ_N && !UART_CLK_EN; endproperty
  a_init: assert property (p_init)
    else $error("pin or clocks active during init");
  property p_sleep;
    REG_REQ.wr && REG_REQ.addr == OFS_PRIMARY && REG_REQ.wdata[CTL_FSLEEP]
      |-> ##3 !UART_CLK_EN;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("clocks run in forced sleep");
  property p_sel;
    age_q > 8'h65 && !sel_q && !$past(sel_q) |-> IRQ_N;
  endproperty
  a_sel: assert property (p_sel)
    else $error("pin active without select");
  property p_gap; TXQ_TAKE |=> !TXQ_TAKE; endproperty
  a_gap: assert property (p_gap)
    else $error("queue taken twice in a row");
  property p_src; TXQ_TAKE |-> $past(TXQ_VALID); endproperty
  a_src: assert property (p_src)
    else $error("take without queue word");
  property p_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word dropped on stall");
  c_rd: cover property (REG_RVALID);
  c_take: cover property (TXQ_TAKE);
  c_stall: cover property (TX_VALID && !TX_READY);
endmodule
bind uafc_core uafc_core_sva u_sva (.MCLK(MCLK), .RST(RST),
  .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .TXQ_VALID(TXQ_VALID), .TXQ_TAKE(TXQ_TAKE), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_READY(TX_READY), .IRQ_N(IRQ_N),
  .UART_CLK_EN(UART_CLK_EN));

// File: verification/uafc_far_end.sv
`timescale 1ns/1ps
// Far-end receiver; ready lags a stall request by one cycle
module uafc_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic stall,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_data
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      got <= 1'b0;
      got_data <= 8'h00;
    end else begin
      tx_ready <= !stall;
      got <= tx_valid && tx_ready;
      got_data <= tx_data;
    end
  end
endmodule

// File: verification/tb_uart_flow_power_irq_control.sv
`timescale 1ns/1ps
// Bench for the flow, power and interrupt control core
module tb_uart_flow_power_irq_control;
  import uafc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rxv = 1'b0, txqv = 1'b0, stall = 1'b0;
  logic rvalid, take, txv, rdy, irq_n, clk_en, got, cts = 1'b1, tick = 1'b0;
  logic [7:0] rdata, txd, got_d, txq_d = 8'h00, rxd = 8'h00;
  logic [7:0] rq[$], tq[$], w[8];
  uafc_reg_req_s req = '0;
  logic [31:0] seed = 32'h0000A344;
  int fails = 0, checked = 0, cyc = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  always #5 clk = ~clk;
  // Revision value is arbitrary
  uafc_core #(.IDLE_LIMIT(8), .REV_ID(8'h3C)) u_dut (.MCLK(clk),
    .RST(rst), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .RX_VALID(rxv), .RX_DATA(rxd), .CHAR_TICK(tick), .TXQ_VALID(txqv),
    .TXQ_DATA(txq_d), .TXQ_LEVEL({7'h00, txqv}), .TXQ_TAKE(take),
    .TX_VALID(txv), .TX_DATA(txd), .TX_READY(rdy), .RX_PIN(!rxv),
    .CTS_N(cts), .GPIO_IN(4'h0), .EXT_CLK(1'b0), .IRQ_N(irq_n),
    .UART_CLK_EN(clk_en));
  uafc_far_end u_far (.clk(clk), .rst(rst), .tx_valid(txv),
    .tx_data(txd), .stall(stall), .tx_ready(rdy), .got(got),
    .got_data(got_d));
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic rx(input logic [7:0] d);
    @(posedge clk);
    rxv <= 1'b1;
    rxd <= d;
    @(posedge clk);
    rxv <= 1'b0;
  endtask
  // Random stall, timeout, and matching of results to oldest notes
  always @(posedge clk) begin
    seed <= xs(seed);
    stall <= seed[0] & seed[1];
    tick <= seed[2];
    cyc <= cyc + 1;
    if (rvalid === 1'b1) chk("read", rdata, rq.size() ? rq.pop_front() : 8'hXX);
    if (got === 1'b1) chk("link", got_d, tq.size() ? tq.pop_front() : 8'hXX);
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (110) @(posedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    rd(OFS_REVISION, 8'h3C);
    rd(OFS_TOP_STAT, TOP_STAT_RST);
    rd(5'h1F, 8'h00);
    acc(1'b1, OFS_MISC_MASK, 8'h20);
    acc(1'b1, OFS_SPC_MASK, 8'h03);
    acc(1'b1, OFS_TOP_MASK, 8'h02);
    acc(1'b1, OFS_PRIMARY, 8'h82);
    acc(1'b1, OFS_HS_CFG, 8'h10);
    acc(1'b1, OFS_PAU1, 8'h13);
    acc(1'b1, OFS_RES1, 8'h11);
    cts <= 1'b0;
    repeat (120) @(posedge clk);
    rd(OFS_MISC_IRQ, 8'h20);
    rd(OFS_MISC_IRQ, 8'h00);
    rd(OFS_TOP_STAT, 8'hE4);
    rx(8'h13);
    repeat (3) @(posedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h00);
    rd(OFS_RECV_HOLD, 8'h00);
    rd(OFS_SPC_IRQ, 8'h02);
    rd(OFS_SPC_IRQ, 8'h00);
    rd(OFS_TOP_STAT, 8'h62);
    repeat (3) @(posedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    // A queue word must wait while paused; a stray one fails on the link
    acc(1'b1, OFS_PRIMARY, 8'h80);
    txq_d <= seed[7:0];
    txqv <= 1'b1;
    repeat (30) @(posedge clk);
    tq.push_back(txq_d);
    rx(8'h11);
    for (int i = 0; i < 60 && take !== 1'b1; i++) @(posedge clk);
    txqv <= 1'b0;
    acc(1'b1, OFS_HS_THR, 8'h01);
    acc(1'b1, OFS_TRIG, 8'h10);
    rd(OFS_TOP_STAT, 8'h62);
    tq.push_back(8'h13);
    acc(1'b1, OFS_HS_CFG, 8'h50);
    for (int i = 0; i < 8; i++) begin
      w[i] = seed[7:0] | 8'h80;
      rx(w[i]);
    end
    repeat (5) @(posedge clk);
    rd(OFS_TOP_STAT, 8'h6A);
    tq.push_back(8'h11);
    for (int i = 0; i < 8; i++) rd(OFS_RECV_HOLD, w[i]);
    repeat (30) @(posedge clk);
    acc(1'b1, OFS_PRIMARY, 8'hA0);
    repeat (4) @(posedge clk);
    chk("clock enable", {7'h00, clk_en}, 8'h00);
    rd(OFS_REVISION, 8'h3C);
    acc(1'b1, OFS_PRIMARY, 8'h80);
    repeat (4) @(posedge clk);
    chk("clock enable", {7'h00, clk_en}, 8'h01);
    chk("link words left", 8'(tq.size()), 8'h00);
    {cts, rst} <= 2'h3;
    @(posedge clk);
    rst <= 1'b0;
    rd(OFS_HS_CFG, 8'h00);
    rd(OFS_TOP_STAT, TOP_STAT_RST);
    chk("irq pin", {7'h00, irq_n}, 8'h00);
    repeat (5) @(posedge clk);
    tally_and_finish();
  end
endmodule
